// ===== logic/mpi_core.sv
// Multichannel parameter store with slot walker and descriptor
// bookkeeping, reached over APB.
// Assumes same-clock descriptor fetch logic and a slot strobe pin.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mpi_core import mpi_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_slot_strobe,
  input wire logic i_desc_done,
  input wire logic i_desc_tx,
  input wire logic [1:0] i_desc_chan,
  input wire logic [15:0] i_desc_status,
  output logic o_rx_slot_go,
  output logic [11:0] o_rx_area_addr,
  output logic [7:0] o_rx_bit_mask,
  output logic o_tx_slot_go,
  output logic [11:0] o_tx_area_addr,
  output logic [7:0] o_tx_bit_mask,
  output logic [31:0] o_desc_addr,
  output logic o_desc_ok,
  output logic o_chan_irq,
  output logic o_rx_enabled,
  output logic o_tx_enabled
);
  logic [GML_W-1:0] gml_r, gml_nxt;
  logic [31:0] dtb_r, dtb_nxt, itb_r, itb_nxt, iptr_r, iptr_nxt;
  logic [15:0] mrbl_r, mrbl_nxt, thr_r, thr_nxt, cnt_r, cnt_nxt;
  logic [31:0] crc32_r, crc32_nxt;
  logic [15:0] crc16_r, crc16_nxt, cst_r, cst_nxt;
  logic [4:0] txs_r, txs_nxt, txc_r, txc_nxt;
  logic [4:0] rxs_r, rxs_nxt, rxc_r, rxc_nxt;
  logic [15:0] rx_tab_r [NSLOT], rx_tab_nxt [NSLOT];
  logic [15:0] tx_tab_r [NSLOT], tx_tab_nxt [NSLOT];
  logic [15:0] ch_mode_r [NCHAN], ch_mode_nxt [NCHAN];
  logic [15:0] ch_mask_r [NCHAN], ch_mask_nxt [NCHAN];
  logic [15:0] ch_rxb_r [NCHAN], ch_rxb_nxt [NCHAN];
  logic [15:0] ch_txb_r [NCHAN], ch_txb_nxt [NCHAN];
  logic [15:0] ch_rxc_r [NCHAN], ch_rxc_nxt [NCHAN];
  logic [15:0] ch_txc_r [NCHAN], ch_txc_nxt [NCHAN];
  logic rx_go_nxt, tx_go_nxt, ok_nxt, irq_nxt;
  logic [11:0] rx_area_nxt, tx_area_nxt;
  logic [7:0] rx_mask_nxt, tx_mask_nxt;
  logic [31:0] desc_addr_nxt, prdata_nxt, rd_data;
  logic pready_nxt, pslverr_nxt, rd_ok;
  logic strobe_q, strobe_d_r, slot_tick;
  logic rx_run, tx_run, wr_en, in_rxtab, in_txtab, in_chan;
  logic [4:0] tab_idx;
  logic [1:0] reg_ch, dch;
  logic [3:0] ch_word;
  logic [15:0] rx_ent, tx_ent;
  logic desc_ent;
  logic [31:0] desc_sum;

  // Slot cursor step; wrap entry returns to table start
  function automatic logic [4:0] next_slot(input logic [4:0] cur,
      input logic [4:0] start, input logic [15:0] transmit_enable_bit);
    next_slot = transmit_enable_bit[SLOT_W_BIT] ? start : 5'(cur + 5'h01);
  endfunction

  // Descriptor cursor step; wrap descriptor returns to base
  function automatic logic [15:0] next_bd(input logic [15:0] cur,
      input logic [15:0] base, input logic [15:0] status);
    next_bd = status[BD_WRAP_BIT] ? base : 16'(cur + BD_STEP);
  endfunction

  // Slot strobe pin crosses in before the edge detect
  mpi_sync2 u_strobe_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_slot_strobe),
    .o_q(strobe_q)
  );

  // Address decode and engine enables
  assign slot_tick = strobe_q & ~strobe_d_r;
  // [R1] multichannel mode gate
  assign rx_run = (gml_r[3:0] == MODE_MULTI) & gml_r[GML_ENR_BIT];
  assign tx_run = (gml_r[3:0] == MODE_MULTI) & gml_r[GML_ENT_BIT];
  assign in_rxtab = (i_paddr[11:7] == RXTAB_SEL);
  assign in_txtab = (i_paddr[11:7] == TXTAB_SEL);
  assign in_chan = (i_paddr[11:8] == CHAN_SEL) & (i_paddr[5:2] <= CHW_TXCUR);
  assign tab_idx = i_paddr[6:2];
  assign reg_ch = i_paddr[7:6];
  assign ch_word = i_paddr[5:2];
  assign wr_en = i_psel & i_penable & o_pready & i_pwrite & rd_ok;
  assign rx_ent = rx_tab_r[rxc_r];
  assign tx_ent = tx_tab_r[txc_r];
  assign dch = i_desc_chan;
  assign desc_ent = ch_mode_r[dch][CM_ENT_BIT];
  // [R3] descriptor address above table base
  assign desc_sum = dtb_r + {16'h0000,
                             i_desc_tx ? ch_txc_r[dch] : ch_rxc_r[dch]};
  assign o_rx_enabled = gml_r[GML_ENR_BIT];
  assign o_tx_enabled = gml_r[GML_ENT_BIT];

  // Read mux; unmapped addresses flag an error
  always_comb begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    if (in_rxtab) begin
      rd_data = {16'h0000, rx_tab_r[tab_idx]};
    end else if (in_txtab) begin
      rd_data = {16'h0000, tx_tab_r[tab_idx]};
    end else if (in_chan) begin
      case (ch_word)
        CHW_MODE: rd_data = {16'h0000, ch_mode_r[reg_ch]};
        CHW_IRQMASK: rd_data = {16'h0000, ch_mask_r[reg_ch]};
        CHW_RXBASE: rd_data = {16'h0000, ch_rxb_r[reg_ch]};
        CHW_TXBASE: rd_data = {16'h0000, ch_txb_r[reg_ch]};
        CHW_RXCUR: rd_data = {16'h0000, ch_rxc_r[reg_ch]};
        default: rd_data = {16'h0000, ch_txc_r[reg_ch]};
      endcase
    end else begin
      case (i_paddr)
        OFF_GML: rd_data = {26'h0000000, gml_r};
        OFF_DTB: rd_data = dtb_r;
        OFF_ITB: rd_data = itb_r;
        OFF_IPTR: rd_data = iptr_r;
        OFF_MRBL: rd_data = {16'h0000, mrbl_r};
        OFF_THR: rd_data = {16'h0000, thr_r};
        OFF_CNT: rd_data = {16'h0000, cnt_r};
        OFF_CRC32: rd_data = crc32_r;
        OFF_CRC16: rd_data = {16'h0000, crc16_r};
        OFF_TXS: rd_data = {27'h0000000, txs_r};
        OFF_TXC: rd_data = {27'h0000000, txc_r};
        OFF_RXS: rd_data = {27'h0000000, rxs_r};
        OFF_RXC: rd_data = {27'h0000000, rxc_r};
        OFF_CST: rd_data = {16'h0000, cst_r};
        OFF_STATUS: rd_data = {30'h00000000, tx_run, rx_run};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // APB answer: ready in the cycle after setup
  always_comb begin
    pready_nxt = i_psel & ~i_penable;
    prdata_nxt = 32'h00000000;
    pslverr_nxt = 1'b0;
    if (i_psel && !i_penable) begin
      prdata_nxt = i_pwrite ? 32'h00000000 : rd_data;
      pslverr_nxt = ~rd_ok;
    end
  end

  // Parameter store, slot walker and descriptor cursors
  always_comb begin
    gml_nxt = gml_r;
    dtb_nxt = dtb_r;
    itb_nxt = itb_r;
    iptr_nxt = iptr_r;
    mrbl_nxt = mrbl_r;
    thr_nxt = thr_r;
    cnt_nxt = cnt_r;
    crc32_nxt = crc32_r;
    crc16_nxt = crc16_r;
    cst_nxt = cst_r;
    txs_nxt = txs_r;
    txc_nxt = txc_r;
    rxs_nxt = rxs_r;
    rxc_nxt = rxc_r;
    rx_tab_nxt = rx_tab_r;
    tx_tab_nxt = tx_tab_r;
    ch_mode_nxt = ch_mode_r;
    ch_mask_nxt = ch_mask_r;
    ch_rxb_nxt = ch_rxb_r;
    ch_txb_nxt = ch_txb_r;
    ch_rxc_nxt = ch_rxc_r;
    ch_txc_nxt = ch_txc_r;
    rx_go_nxt = 1'b0;
    tx_go_nxt = 1'b0;
    rx_area_nxt = o_rx_area_addr;
    tx_area_nxt = o_tx_area_addr;
    rx_mask_nxt = o_rx_bit_mask;
    tx_mask_nxt = o_tx_bit_mask;
    ok_nxt = 1'b0;
    irq_nxt = 1'b0;
    desc_addr_nxt = desc_sum;
    // [R8] walk receive slots, wrap to start
    if (slot_tick && rx_run) begin
      rxc_nxt = next_slot(rxc_r, rxs_r, rx_ent);
      if (rx_ent[SLOT_V_BIT]) begin
        rx_go_nxt = 1'b1;
        // [R10] channel area from slot pointer
        rx_area_nxt = {rx_ent[SLOT_CP_MSB:SLOT_CP_LSB], AREA_ZERO};
        // [R9] bit mask per slot
        rx_mask_nxt = rx_ent[MASK_W-1:0];
      end
    end
    // [R8] walk transmit slots, wrap to start
    if (slot_tick && tx_run) begin
      txc_nxt = next_slot(txc_r, txs_r, tx_ent);
      if (tx_ent[SLOT_V_BIT]) begin
        tx_go_nxt = 1'b1;
        tx_area_nxt = {tx_ent[SLOT_CP_MSB:SLOT_CP_LSB], AREA_ZERO};
        tx_mask_nxt = tx_ent[MASK_W-1:0];
      end
    end
    if (i_desc_done) begin
      if (i_desc_tx) begin
        // [R20] [R22] ready descriptor, channel enabled
        if (desc_ent && i_desc_status[BD_READY_BIT]) begin
          ok_nxt = 1'b1;
          ch_txc_nxt[dch] = next_bd(ch_txc_r[dch], ch_txb_r[dch],
                                    i_desc_status);
          // [R17] masked transmit interrupt
          irq_nxt = i_desc_status[BD_INT_BIT] &
                    ch_mask_r[dch][IRQ_TXB_BIT];
        end
      end else if (i_desc_status[BD_READY_BIT]) begin
        // [R19] empty receive descriptor taken
        ok_nxt = 1'b1;
        ch_rxc_nxt[dch] = next_bd(ch_rxc_r[dch], ch_rxb_r[dch],
                                  i_desc_status);
        // [R17] masked receive interrupt
        irq_nxt = i_desc_status[BD_INT_BIT] &
                  ch_mask_r[dch][IRQ_RXB_BIT];
      end
    end
    // Software writes win over engine updates
    if (wr_en) begin
      if (in_rxtab) begin
        rx_tab_nxt[tab_idx] = i_pwdata[15:0];
      end else if (in_txtab) begin
        tx_tab_nxt[tab_idx] = i_pwdata[15:0];
      end else if (in_chan) begin
        case (ch_word)
          CHW_MODE: ch_mode_nxt[reg_ch] = i_pwdata[15:0];
          CHW_IRQMASK: ch_mask_nxt[reg_ch] = i_pwdata[15:0];
          // [R13] base write also loads cursor
          CHW_RXBASE: begin
            ch_rxb_nxt[reg_ch] = i_pwdata[15:0];
            ch_rxc_nxt[reg_ch] = i_pwdata[15:0];
          end
          CHW_TXBASE: begin
            ch_txb_nxt[reg_ch] = i_pwdata[15:0];
            ch_txc_nxt[reg_ch] = i_pwdata[15:0];
          end
          CHW_RXCUR: ch_rxc_nxt[reg_ch] = i_pwdata[15:0];
          default: ch_txc_nxt[reg_ch] = i_pwdata[15:0];
        endcase
      end else begin
        case (i_paddr)
          OFF_GML: gml_nxt = i_pwdata[GML_W-1:0];
          OFF_DTB: dtb_nxt = i_pwdata;
          OFF_ITB: itb_nxt = i_pwdata;
          OFF_IPTR: iptr_nxt = i_pwdata;
          OFF_MRBL: mrbl_nxt = i_pwdata[15:0];
          OFF_THR: thr_nxt = i_pwdata[15:0];
          OFF_CNT: cnt_nxt = i_pwdata[15:0];
          OFF_CRC32: crc32_nxt = i_pwdata;
          OFF_CRC16: crc16_nxt = i_pwdata[15:0];
          OFF_TXS: txs_nxt = i_pwdata[4:0];
          OFF_TXC: txc_nxt = i_pwdata[4:0];
          OFF_RXS: rxs_nxt = i_pwdata[4:0];
          OFF_RXC: rxc_nxt = i_pwdata[4:0];
          OFF_CST: cst_nxt = i_pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Register everything; channel modes reset with enables clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gml_r <= '0;
      dtb_r <= '0;
      itb_r <= '0;
      iptr_r <= '0;
      mrbl_r <= '0;
      thr_r <= THR_INIT;
      cnt_r <= THR_INIT;
      crc32_r <= CRC32_RESIDUE;
      crc16_r <= CRC16_RESIDUE;
      cst_r <= CST_INIT;
      txs_r <= '0;
      txc_r <= '0;
      rxs_r <= '0;
      rxc_r <= '0;
      rx_tab_r <= '{default: '0};
      tx_tab_r <= '{default: '0};
      ch_mode_r <= '{default: '0};
      ch_mask_r <= '{default: '0};
      ch_rxb_r <= '{default: '0};
      ch_txb_r <= '{default: '0};
      ch_rxc_r <= '{default: '0};
      ch_txc_r <= '{default: '0};
      strobe_d_r <= 1'b0;
      o_rx_slot_go <= 1'b0;
      o_tx_slot_go <= 1'b0;
      o_rx_area_addr <= '0;
      o_tx_area_addr <= '0;
      o_rx_bit_mask <= '0;
      o_tx_bit_mask <= '0;
      o_desc_addr <= '0;
      o_desc_ok <= 1'b0;
      o_chan_irq <= 1'b0;
      o_prdata <= '0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      gml_r <= gml_nxt;
      dtb_r <= dtb_nxt;
      itb_r <= itb_nxt;
      iptr_r <= iptr_nxt;
      mrbl_r <= mrbl_nxt;
      thr_r <= thr_nxt;
      cnt_r <= cnt_nxt;
      crc32_r <= crc32_nxt;
      crc16_r <= crc16_nxt;
      cst_r <= cst_nxt;
      txs_r <= txs_nxt;
      txc_r <= txc_nxt;
      rxs_r <= rxs_nxt;
      rxc_r <= rxc_nxt;
      rx_tab_r <= rx_tab_nxt;
      tx_tab_r <= tx_tab_nxt;
      ch_mode_r <= ch_mode_nxt;
      ch_mask_r <= ch_mask_nxt;
      ch_rxb_r <= ch_rxb_nxt;
      ch_txb_r <= ch_txb_nxt;
      ch_rxc_r <= ch_rxc_nxt;
      ch_txc_r <= ch_txc_nxt;
      strobe_d_r <= strobe_q;
      o_rx_slot_go <= rx_go_nxt;
      o_tx_slot_go <= tx_go_nxt;
      o_rx_area_addr <= rx_area_nxt;
      o_tx_area_addr <= tx_area_nxt;
      o_rx_bit_mask <= rx_mask_nxt;
      o_tx_bit_mask <= tx_mask_nxt;
      o_desc_addr <= desc_addr_nxt;
      o_desc_ok <= ok_nxt;
      o_chan_irq <= irq_nxt;
      o_prdata <= prdata_nxt;
      o_pready <= pready_nxt;
      o_pslverr <= pslverr_nxt;
    end
  end

  // Checks on the walker and descriptor handling
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence rx_step_s;
    slot_tick && rx_run && !wr_en;
  endsequence
  sequence rx_taken_s;
    i_desc_done && !i_desc_tx && !wr_en;
  endsequence

  slot_wrap_a: assert property ( // [R8]
    rx_step_s and rx_ent[SLOT_W_BIT] |=> rxc_r == $past(rxs_r))
    else $error("receive slot cursor did not wrap to start");
  slot_step_a: assert property ( // [R8]
    rx_step_s and !rx_ent[SLOT_W_BIT]
    |=> rxc_r == 5'($past(rxc_r) + 5'h01))
    else $error("receive slot cursor did not step");
  slot_skip_a: assert property ( // [R8]
    rx_step_s and !rx_ent[SLOT_V_BIT] |=> !o_rx_slot_go)
    else $error("invalid slot was processed");
  slot_mask_a: assert property ( // [R9]
    rx_step_s and rx_ent[SLOT_V_BIT]
    |=> o_rx_slot_go && o_rx_bit_mask == $past(rx_ent[7:0]))
    else $error("slot bit mask not passed on");
  area_addr_a: assert property ( // [R10]
    o_rx_slot_go |-> o_rx_area_addr[5:0] == AREA_ZERO)
    else $error("channel area low bits not zero");
  desc_base_a: assert property ( // [R3]
    i_desc_done |=> o_desc_addr == $past(desc_sum))
    else $error("descriptor address not base plus cursor");
  base_copy_a: assert property ( // [R13]
    wr_en && in_chan && ch_word == CHW_RXBASE
    |=> ch_rxc_r[$past(reg_ch)] == $past(i_pwdata[15:0]))
    else $error("cursor not loaded with descriptor base");
  rx_empty_a: assert property ( // [R19]
    rx_taken_s |=> o_desc_ok == $past(i_desc_status[BD_READY_BIT]))
    else $error("receive descriptor acceptance wrong");
  tx_gate_a: assert property ( // [R22]
    i_desc_done && i_desc_tx && !desc_ent |=> !o_desc_ok)
    else $error("transmit taken on disabled channel");
  irq_mask_a: assert property ( // [R17]
    o_chan_irq |-> $past(i_desc_done) && o_desc_ok
    && $past(i_desc_status[BD_INT_BIT])
    && ($past(i_desc_tx) ? $past(ch_mask_r[dch][IRQ_TXB_BIT])
                         : $past(ch_mask_r[dch][IRQ_RXB_BIT])))
    else $error("channel interrupt without taken descriptor");
endmodule
`default_nettype wire

// ===== logic/mpi_pkg.sv
// Constants for the multichannel parameter block: register map,
// field layouts, reset values.
// Assumes a 32-bit APB master with 12-bit byte addresses.
// Notes on behaviour
// [R1] Mode field must hold multichannel code
// [R2] Receive and transmit enables stay clear during setup
// [R3] Descriptors sit in window above table base
// [R4] Receive buffer length multiple of four, over thirty
// [R5] Frame counter starts equal to frame threshold
// [R6] Load both CRC check constants before running
// [R7] Interrupt pointer starts at interrupt table base
// [R8] Valid bit on used slots, wrap on last
// [R9] Slot mask selects processed bits of slot
// [R10] Slot pointer gives upper channel area bits
// [R11] Slot start and cursor point at first entry
// [R12] Controller state word gets its fixed value
// [R13] Descriptor cursors start as copies of bases
// [R14] Internal state words get typical variant values
// [R15] Bit stuffing state gets fixed start value
// [R16] Bit unstuffing state depends on channel protocol
// [R17] Channel interrupt only when its mask set
// [R18] Frame or buffer length limits per protocol
// [R19] Receive descriptor usable only when marked empty
// [R20] Transmit descriptor sent only when marked ready
// [R21] Interrupt table entries clear, last one wraps
// [R22] Channel mode: protocol, flags, enables start clear
// [R23] Finish all parameter writes before enabling
package mpi_pkg;
  localparam int unsigned NSLOT = 32;
  localparam int unsigned NCHAN = 4;
  // Global register byte offsets
  localparam logic [11:0] OFF_GML = 12'h000;
  localparam logic [11:0] OFF_DTB = 12'h004;
  localparam logic [11:0] OFF_ITB = 12'h008;
  localparam logic [11:0] OFF_IPTR = 12'h00C;
  localparam logic [11:0] OFF_MRBL = 12'h010;
  localparam logic [11:0] OFF_THR = 12'h014;
  localparam logic [11:0] OFF_CNT = 12'h018;
  localparam logic [11:0] OFF_CRC32 = 12'h01C;
  localparam logic [11:0] OFF_CRC16 = 12'h020;
  localparam logic [11:0] OFF_TXS = 12'h024;
  localparam logic [11:0] OFF_TXC = 12'h028;
  localparam logic [11:0] OFF_RXS = 12'h02C;
  localparam logic [11:0] OFF_RXC = 12'h030;
  localparam logic [11:0] OFF_CST = 12'h034;
  localparam logic [11:0] OFF_STATUS = 12'h038;
  // Slot tables and channel areas
  localparam logic [4:0] RXTAB_SEL = 5'h02;
  localparam logic [4:0] TXTAB_SEL = 5'h03;
  localparam logic [3:0] CHAN_SEL = 4'h2;
  localparam logic [3:0] CHW_MODE = 4'h0;
  localparam logic [3:0] CHW_IRQMASK = 4'h1;
  localparam logic [3:0] CHW_RXBASE = 4'h2;
  localparam logic [3:0] CHW_TXBASE = 4'h3;
  localparam logic [3:0] CHW_RXCUR = 4'h4;
  localparam logic [3:0] CHW_TXCUR = 4'h5;
  // General mode low fields
  localparam logic [3:0] MODE_MULTI = 4'hA;
  localparam int unsigned GML_W = 6;
  localparam int unsigned GML_ENT_BIT = 4;
  localparam int unsigned GML_ENR_BIT = 5;
  // Slot entry fields
  localparam int unsigned SLOT_V_BIT = 15;
  localparam int unsigned SLOT_W_BIT = 14;
  localparam int unsigned SLOT_CP_LSB = 8;
  localparam int unsigned SLOT_CP_MSB = 13;
  localparam int unsigned MASK_W = 8;
  localparam logic [5:0] AREA_ZERO = 6'h00;
  // Channel mode control fields
  localparam int unsigned CM_HDLC_BIT = 15;
  localparam int unsigned CM_ENT_BIT = 12;
  localparam int unsigned CM_POL_BIT = 10;
  // Descriptor status fields and step
  localparam int unsigned BD_READY_BIT = 15;
  localparam int unsigned BD_WRAP_BIT = 13;
  localparam int unsigned BD_INT_BIT = 12;
  localparam logic [15:0] BD_STEP = 16'h0008;
  // Channel interrupt mask bits
  localparam int unsigned IRQ_RXB_BIT = 0;
  localparam int unsigned IRQ_TXB_BIT = 1;
  // Reset values
  localparam logic [31:0] CRC32_RESIDUE = 32'hDEBB20E3;
  localparam logic [15:0] CRC16_RESIDUE = 16'hF0B8;
  localparam logic [15:0] CST_INIT = 16'h8000;
  localparam logic [15:0] THR_INIT = 16'h0001;
endpackage

// ===== logic/mpi_sync2.sv
// Two-stage synchroniser for pin inputs.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module mpi_sync2 (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  // Next values are just the shifted input
  always_comb begin
    meta_nxt = i_d;
    q_nxt = meta_r;
  end

  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      o_q <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== tb/mpi_host_model.sv
// Host model that writes the parameter store over APB.
// Assumes a registered slave that answers with pready high.
`timescale 1ns/1ps
`default_nettype none
module mpi_host_model (
  input wire logic i_clk,
  input wire logic i_pready,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata
);
  // Bus idle from time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
  end

  // One transfer, held until pready is seen at an edge or 20 edges pass
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output bit to);
    int n;
    n = 0;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    // Ready is sampled at the rising edge that ends the access
    do begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 20);
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_pwdata <= ~d;
    to = (i_pready !== 1'b1);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_multichannel_param_init.sv
// Self-checking bench for the multichannel parameter store.
// Assumes the register map and hand-over timing of mpi_core.
`timescale 1ns/1ps
`default_nettype none
module tb_multichannel_param_init import mpi_pkg::*; ;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel, penable, pwrite, o_pready, o_pslverr;
  logic [11:0] paddr, o_rx_area_addr, o_tx_area_addr;
  logic [31:0] pwdata, o_prdata, o_desc_addr;
  logic slot_strobe = 1'b0;
  logic desc_done = 1'b0;
  logic desc_tx = 1'b0;
  logic [1:0] desc_chan = 2'h0;
  logic [15:0] desc_status = 16'h0;
  logic o_rx_slot_go, o_tx_slot_go, o_desc_ok, o_chan_irq;
  logic o_rx_enabled, o_tx_enabled;
  logic [7:0] o_rx_bit_mask, o_tx_bit_mask;
  int err_total = 0;
  int total_checks = 0;
  logic [33:0] qb[$];
  logic [19:0] qrx[$];
  logic [19:0] qtx[$];
  logic qd[$];

  always #5 i_clk = ~i_clk;

  mpi_host_model mpi_host_model_i (.i_clk(i_clk), .i_pready(o_pready),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata));

  mpi_core mpi_core_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_slot_strobe(slot_strobe),
    .i_desc_done(desc_done), .i_desc_tx(desc_tx),
    .i_desc_chan(desc_chan), .i_desc_status(desc_status),
    .o_rx_slot_go(o_rx_slot_go), .o_rx_area_addr(o_rx_area_addr),
    .o_rx_bit_mask(o_rx_bit_mask), .o_tx_slot_go(o_tx_slot_go),
    .o_tx_area_addr(o_tx_area_addr), .o_tx_bit_mask(o_tx_bit_mask),
    .o_desc_addr(o_desc_addr), .o_desc_ok(o_desc_ok),
    .o_chan_irq(o_chan_irq), .o_rx_enabled(o_rx_enabled),
    .o_tx_enabled(o_tx_enabled));

  task automatic fail(input string m);
    $display("mismatch %0t %s", $time, m);
    err_total++;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Bus answer: data on every answer (zero for writes), error flag always
  task automatic cmp_bus(input logic [33:0] e);
    total_checks++;
    if (o_pslverr !== e[32] || o_prdata !== e[31:0])
      fail("bus answer");
  endtask

  task automatic cmp_word(input logic [31:0] got, e, input string m);
    total_checks++;
    if (got !== e)
      fail(m);
  endtask

  task automatic cmp_desc(input logic e);
    total_checks++;
    if (o_chan_irq !== e)
      fail("channel irq flag");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic err = 1'b0);
    bit to;
    qb.push_back({1'b0, err, 32'h0});
    mpi_host_model_i.xfer(1'b1, a, d, to);
    if (to) begin
      fail("no bus answer");
      conclude();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic err = 1'b0);
    bit to;
    qb.push_back({1'b1, err, d});
    mpi_host_model_i.xfer(1'b0, a, 32'h0, to);
    if (to) begin
      fail("no bus answer");
      conclude();
    end
  endtask

  // One slot strobe, long enough for the pin synchroniser
  task automatic tick;
    @(posedge i_clk);
    slot_strobe <= 1'b1;
    repeat (4) @(posedge i_clk);
    slot_strobe <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask

  task automatic desc(input logic tx, input logic [15:0] st,
                      input logic ok, input logic irq);
    if (ok)
      qd.push_back(irq);
    @(posedge i_clk);
    desc_done <= 1'b1;
    desc_tx <= tx;
    desc_status <= st;
    @(posedge i_clk);
    desc_done <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  // Monitor: each answer takes the oldest expectation
  always @(negedge i_clk) begin
    if (i_rst_n && o_pready) begin
      if (qb.size() == 0) fail("stray bus answer");
      else cmp_bus(qb.pop_front());
    end
    if (i_rst_n && o_rx_slot_go) begin
      if (qrx.size() == 0) fail("stray rx slot");
      else cmp_word({o_rx_area_addr, o_rx_bit_mask}, qrx.pop_front(), "rx");
    end
    if (i_rst_n && o_tx_slot_go) begin
      if (qtx.size() == 0) fail("stray tx slot");
      else cmp_word({o_tx_area_addr, o_tx_bit_mask}, qtx.pop_front(), "tx");
    end
    if (i_rst_n && o_desc_ok) begin
      if (qd.size() == 0) fail("stray descriptor accept");
      else cmp_desc(qd.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    fail("run too long");
    conclude();
  end

  initial begin
    logic [15:0] transmit_enable_bit[4];
    logic [11:0] ca;
    logic [31:0] m;
    logic [1:0] ch;
    void'($urandom(32'hC9BC));
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(OFF_THR, 32'h1);
    rd(OFF_CNT, 32'h1);
    rd(OFF_CRC32, CRC32_RESIDUE);
    rd(OFF_CRC16, {16'h0, CRC16_RESIDUE});
    rd(OFF_CST, {16'h0, CST_INIT});
    rd(OFF_GML, 32'h0);
    $display("test reset_values done");
    wr(OFF_GML, {28'h0, MODE_MULTI});
    rd(OFF_GML, {28'h0, MODE_MULTI});
    wr(OFF_ITB, 32'h1230);
    wr(OFF_IPTR, 32'h1230);
    rd(OFF_IPTR, 32'h1230);
    m = 32'h20 + 32'h4 * ($urandom % 16);
    wr(OFF_MRBL, m);
    rd(OFF_MRBL, m);
    wr(12'h0F0, 32'hFFFF_FFFF, 1'b1);
    rd(12'h0F0, 32'h0, 1'b1);
    wr(OFF_STATUS, 32'hFFFF_FFFF);
    rd(OFF_STATUS, 32'h0);
    $display("test global_regs done");
    for (int i = 0; i < 4; i++) begin
      transmit_enable_bit[i] = {i != 2, i == 3, 6'($urandom), 8'($urandom)};
      wr(12'h100 + 12'(4 * i), {16'h0, transmit_enable_bit[i]});
      wr(12'h180 + 12'(4 * i), {16'h0, transmit_enable_bit[i]});
    end
    wr(OFF_RXS, 32'h0);
    wr(OFF_RXC, 32'h0);
    wr(OFF_TXS, 32'h0);
    wr(OFF_TXC, 32'h0);
    tick();
    wr(OFF_GML, {26'h0, 2'b11, 4'h0});
    rd(OFF_STATUS, 32'h0);
    wr(OFF_GML, {26'h0, 2'b11, MODE_MULTI});
    rd(OFF_STATUS, 32'h3);
    cmp_word({30'h0, o_tx_enabled, o_rx_enabled}, 32'h3, "enables");
    for (int k = 0; k < 6; k++) begin
      if (transmit_enable_bit[k % 4][15]) begin
        qrx.push_back({transmit_enable_bit[k % 4][13:8], 6'h00, transmit_enable_bit[k % 4][7:0]});
        qtx.push_back({transmit_enable_bit[k % 4][13:8], 6'h00, transmit_enable_bit[k % 4][7:0]});
      end
      tick();
    end
    wr(OFF_GML, {28'h0, MODE_MULTI});
    @(posedge i_clk);
    cmp_word({30'h0, o_tx_enabled, o_rx_enabled}, 32'h0, "enables");
    cmp_word(32'(qrx.size() + qtx.size()), 32'h0, "slots missing");
    $display("test slot_walk done");
    ch = 2'($urandom);
    ca = 12'h200 + {4'h0, ch, 6'h00};
    desc_chan <= ch;
    wr(OFF_DTB, 32'h0001_0000);
    wr(ca + 12'h4, 32'h1);
    wr(ca + 12'h8, 32'h10);
    wr(ca + 12'hC, 32'h18);
    wr(ca, 32'h0);
    rd(ca + 12'h10, 32'h10);
    rd(ca + 12'h14, 32'h18);
    desc(1'b0, 16'h9000, 1'b1, 1'b1);
    desc(1'b0, 16'h1000, 1'b0, 1'b0);
    desc(1'b1, 16'h8000, 1'b0, 1'b0);
    wr(ca, 32'h9007);
    rd(ca, 32'h9007);
    desc(1'b1, 16'h9000, 1'b1, 1'b0);
    rd(ca + 12'h10, 32'h18);
    rd(ca + 12'h14, 32'h20);
    desc(1'b0, 16'hA000, 1'b1, 1'b0);
    rd(ca + 12'h10, 32'h10);
    cmp_word(o_desc_addr, 32'h0001_0010, "descriptor address");
    $display("test descriptors done");
    repeat (10) @(posedge i_clk);
    cmp_word(32'(qb.size() + qd.size()), 32'h0, "answers missing");
    conclude();
  end
endmodule
`default_nettype wire
